//--- core/mmev_pkg.sv
// Purpose: Constants for the memory map, vector table and reset combiner.
// Assumes: 16-bit CPU address space, 125 MHz core clock.
// Notes:   Oscillator ticks arrive as a one-cycle enable from a divider.
package mmev_pkg;
   localparam logic [15:0] ROM_BASE        = 16'h0000;
   localparam logic [15:0] ROM_END_SMALL   = 16'h7FFF;
   localparam logic [15:0] ROM_END_LARGE   = 16'hEFFF;
   localparam logic [15:0] RAM_BASE        = 16'hF000;
   localparam logic [15:0] RAM_END         = 16'hF5FF;
   localparam logic [15:0] DISP_BASE       = 16'hF800;
   localparam logic [15:0] DISP_END        = 16'hFD42;
   localparam logic [15:0] IO_BASE         = 16'hFF00;
   localparam logic [15:0] IO_END          = 16'hFFFF;
   localparam logic [15:0] VEC_TABLE_END   = 16'h0023;
   localparam logic [15:0] VEC_RESERVED    = 16'h0024;
   localparam logic [15:0] SWI_BASE        = 16'h0026;
   localparam logic [15:0] SWI_END         = 16'h00FF;
   localparam logic [15:0] VEC_RESET       = 16'h0000;
   localparam int          NUM_SRC         = 18;
   localparam int          SRC_W           = 5;
   localparam int          LVL_W           = 2;
   // Oscillator-period counts (fosc1 = 32.768 kHz).
   localparam logic [15:0] OSC_STAB_TICKS  = 16'h2000;
   localparam logic [15:0] DROP_SAMPLE_TICKS = 16'h00F8;
   localparam logic [15:0] KEY_HOLD_TICKS  = 16'hFFFF;
   localparam logic [15:0] RESET_PULSE_TICKS = 16'h0040;
   localparam logic [2:0]  DROP_LOW_SAMPLES = 3'h4;
   localparam logic [1:0]  KEY_SEL_NONE    = 2'h0;
   localparam logic [1:0]  KEY_SEL_TWO     = 2'h1;
   localparam logic [1:0]  KEY_SEL_THREE   = 2'h2;
   localparam logic [1:0]  KEY_SEL_FOUR    = 2'h3;
   typedef enum logic [1:0] {RS_HOLD, RS_WAIT, RS_VECTOR, RS_RUN} mmev_rst_type;
endpackage

//--- core/mmev_top.sv
// Purpose: Address decoder, exception vector selection and reset combiner.
// Assumes: CPU fetches the two vector bytes itself; osc_tick_i pulses once
//          per oscillator period; all inputs synchronous to core_clk_i.
// Notes:   Stacking of flags and PC is done by the core on our entry pulse.
// Behaviour
// - ROM ends 7FFF or EFFF by variant
// - RAM selected at F000 through F5FF
// - I/O selected at FF00 through FFFF
// - Display selected F800 through FD42 inclusive
// - 0000 through 0023 is vector table
// - Software vectors even pairs 0026 to 00FF
// - Fixed two-byte vector order from bottom
// - Highest-ranked pending source served first
// - Vector 0024 reserved, never issued
// - Handler address is low byte then high
// - Higher programmed level beats fixed rank
// - Non-reset exceptions save flags and PC
// - Custom branch condition is never driven
// - Reset from pin, keys, or supply detector
// - After release, fetch vector at 0000/0001
// - Start waits 8192 osc periods, plus 248 with detector on
// - Key reset needs two-second hold, bypassable
// - Detector asserts after four low samples
`timescale 1ns/10ps
module mmev_top (
   input  wire logic                                  core_clk_i,
   input  wire logic                                  srst_i,
   input  wire logic                                  large_rom_i,
   input  wire logic [15:0]                           cpu_addr_i,
   input  wire logic                                  cpu_rd_i,
   input  wire logic                                  cpu_wr_i,
   output logic                                       rom_sel_o,
   output logic                                       ram_sel_o,
   output logic                                       disp_sel_o,
   output logic                                       io_sel_o,
   output logic                                       vec_area_o,
   output logic                                       swi_vec_ok_o,
   input  wire logic [mmev_pkg::NUM_SRC-1:0]           exc_req_i,
   input  wire logic [mmev_pkg::NUM_SRC*mmev_pkg::LVL_W-1:0] exc_level_i,
   input  wire logic                                  vec_byte_valid_i,
   input  wire logic [7:0]                            vec_byte_i,
   output logic                                       exc_valid_o,
   output logic [mmev_pkg::SRC_W-1:0]                 exc_src_o,
   output logic [15:0]                                exc_vector_o,
   output logic                                       save_context_o,
   output logic [15:0]                                handler_addr_o,
   output logic                                       handler_valid_o,
   output logic                                       custom_branch_condition_o,
   input  wire logic                                  reset_pin_n_i,
   input  wire logic [3:0]                            key_input_group_low_n_i,
   input  wire logic [1:0]                            key_sel_i,
   input  wire logic                                  supply_drop_detector_en_i,
   input  wire logic                                  supply_drop_detector_sample_i,
   input  wire logic                                  supply_below_level0_i,
   input  wire logic                                  supply_above_level2_i,
   input  wire logic                                  sleep_i,
   input  wire logic                                  osc_tick_i,
   output logic                                       cpu_reset_o,
   output logic                                       reset_vec_fetch_o
);
   typedef struct packed {
      mmev_pkg::mmev_rst_type  rst;
      logic [15:0]             wait_cnt;
      logic [15:0]             key_cnt;
      logic [15:0]             pulse_cnt;
      logic                    key_rst;
      logic [2:0]              drop_cnt;
      logic                    drop_rst;
      logic                    hi_phase;
      logic [7:0]              lo_byte;
      logic [15:0]             handler;
      logic                    handler_valid;
      logic                    sel_rom;
      logic                    sel_ram;
      logic                    sel_disp;
      logic                    sel_io;
   } mmev_top_type;
   mmev_top_type s_q, s_d;
   logic key_all_low;
   logic any_src;
   logic access;

   mmev_vec_sel u_vec_sel (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .req_i      (exc_req_i),
      .level_i    (exc_level_i),
      .valid_o    (exc_valid_o),
      .src_o      (exc_src_o),
      .vector_o   (exc_vector_o)
   );

   // ------------------------------------------------------------
   // Key combination and reset source merge
   // ------------------------------------------------------------
   always_comb begin
      if (key_sel_i == mmev_pkg::KEY_SEL_TWO) begin
         key_all_low = ~|key_input_group_low_n_i[1:0];
      end else if (key_sel_i == mmev_pkg::KEY_SEL_THREE) begin
         key_all_low = ~|key_input_group_low_n_i[2:0];
      end else if (key_sel_i == mmev_pkg::KEY_SEL_FOUR) begin
         key_all_low = ~|key_input_group_low_n_i;
      end else begin
         key_all_low = 1'b0;
      end
   end

   assign any_src = !reset_pin_n_i || s_q.key_rst || s_q.drop_rst;
   assign access  = cpu_rd_i || cpu_wr_i;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Hold timer runs at oscillator rate; sleep skips it entirely.
      if (!key_all_low) begin
         s_d.key_cnt = '0;
         s_d.key_rst = 1'b0;
      // A timed pulse that has already fired is not re-armed by the wait after it,
      // so the CPU restarts even while the keys stay held.
      end else if (sleep_i || (s_q.rst == mmev_pkg::RS_WAIT
                               && s_q.key_cnt != mmev_pkg::KEY_HOLD_TICKS)) begin
         s_d.key_rst = 1'b1;
      end else if (osc_tick_i && s_q.key_cnt != mmev_pkg::KEY_HOLD_TICKS) begin
         s_d.key_cnt = s_q.key_cnt + 16'h0001;
         if (s_q.key_cnt + 16'h0001 == mmev_pkg::KEY_HOLD_TICKS) begin
            s_d.key_rst   = 1'b1;
            s_d.pulse_cnt = '0;
         end
      end
      // A timed key reset is a finite pulse so the CPU restarts while held.
      if (s_q.key_rst && !sleep_i && s_q.key_cnt == mmev_pkg::KEY_HOLD_TICKS && osc_tick_i) begin
         s_d.pulse_cnt = s_q.pulse_cnt + 16'h0001;
         if (s_q.pulse_cnt + 16'h0001 == mmev_pkg::RESET_PULSE_TICKS) begin
            s_d.key_rst = 1'b0;
         end
      end
      // Four successive low samples set; recovery to level 2 or disabling the detector clears.
      if (!supply_drop_detector_en_i) begin
         s_d.drop_cnt = '0;
         s_d.drop_rst = 1'b0;
      end else if (supply_drop_detector_sample_i) begin
         if (supply_below_level0_i) begin
            if (s_q.drop_cnt + 3'h1 >= mmev_pkg::DROP_LOW_SAMPLES) begin
               s_d.drop_rst = 1'b1;
            end else begin
               s_d.drop_cnt = s_q.drop_cnt + 3'h1;
            end
         end else begin
            s_d.drop_cnt = '0;
            if (supply_above_level2_i) begin
               s_d.drop_rst = 1'b0;
            end
         end
      end
      // Reset sequencer.
      case (s_q.rst)
         mmev_pkg::RS_HOLD: begin
            s_d.wait_cnt = '0;
            if (!any_src) begin
               s_d.rst = mmev_pkg::RS_WAIT;
            end
         end
         mmev_pkg::RS_WAIT: begin
            if (any_src) begin
               s_d.rst = mmev_pkg::RS_HOLD;
            end else if (osc_tick_i) begin
               s_d.wait_cnt = s_q.wait_cnt + 16'h0001;
               // Stabilisation wait, lengthened when the detector is used.
               if (s_q.wait_cnt + 16'h0001 >= (supply_drop_detector_en_i
                     ? mmev_pkg::OSC_STAB_TICKS + mmev_pkg::DROP_SAMPLE_TICKS
                     : mmev_pkg::OSC_STAB_TICKS)) begin
                  s_d.rst = mmev_pkg::RS_VECTOR;
               end
            end
         end
         mmev_pkg::RS_VECTOR: begin
            s_d.rst = any_src ? mmev_pkg::RS_HOLD : mmev_pkg::RS_RUN;
         end
         default: begin
            if (any_src) begin
               s_d.rst = mmev_pkg::RS_HOLD;
            end
         end
      endcase
      // Handler address assembly: low byte first, then high.
      s_d.handler_valid = 1'b0;
      if (exc_valid_o || s_q.rst == mmev_pkg::RS_VECTOR) begin
         s_d.hi_phase = 1'b0;
      end else if (vec_byte_valid_i) begin
         if (!s_q.hi_phase) begin
            s_d.lo_byte  = vec_byte_i;
            s_d.hi_phase = 1'b1;
         end else begin
            s_d.handler       = {vec_byte_i, s_q.lo_byte};
            s_d.handler_valid = 1'b1;
            s_d.hi_phase      = 1'b0;
         end
      end
      // Region decode; gaps leave every select low.
      s_d.sel_rom  = access && (cpu_addr_i <= (large_rom_i ? mmev_pkg::ROM_END_LARGE
                                                         : mmev_pkg::ROM_END_SMALL));
      s_d.sel_ram  = access && cpu_addr_i >= mmev_pkg::RAM_BASE
                            && cpu_addr_i <= mmev_pkg::RAM_END;
      s_d.sel_disp = access && cpu_addr_i >= mmev_pkg::DISP_BASE
                            && cpu_addr_i <= mmev_pkg::DISP_END;
      s_d.sel_io   = access && cpu_addr_i >= mmev_pkg::IO_BASE;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_q     <= '0;
         s_q.rst <= mmev_pkg::RS_HOLD;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rom_sel_o    = s_q.sel_rom;
   assign ram_sel_o    = s_q.sel_ram;
   assign disp_sel_o   = s_q.sel_disp;
   assign io_sel_o     = s_q.sel_io;
   assign vec_area_o   = cpu_addr_i <= mmev_pkg::VEC_TABLE_END;
   assign swi_vec_ok_o = cpu_addr_i >= mmev_pkg::SWI_BASE && cpu_addr_i <= mmev_pkg::SWI_END
                         && !cpu_addr_i[0];
   assign save_context_o = exc_valid_o && exc_src_o != '0;
   assign handler_addr_o  = s_q.handler;
   assign handler_valid_o = s_q.handler_valid;
   assign custom_branch_condition_o = 1'b0;
   assign cpu_reset_o       = s_q.rst != mmev_pkg::RS_RUN;
   assign reset_vec_fetch_o = s_q.rst == mmev_pkg::RS_VECTOR;
endmodule

//--- core/mmev_vec_sel.sv
// Purpose: Picks the winning exception source and its vector address.
// Assumes: Source 0 is reset, source 17 is clock timer 1 Hz.
// Notes:   Output is registered; one cycle from request to vector.
`timescale 1ns/10ps
module mmev_vec_sel (
   input  wire logic                                 core_clk_i,
   input  wire logic                                 srst_i,
   input  wire logic [mmev_pkg::NUM_SRC-1:0]          req_i,
   input  wire logic [mmev_pkg::NUM_SRC*mmev_pkg::LVL_W-1:0] level_i,
   output logic                                       valid_o,
   output logic [mmev_pkg::SRC_W-1:0]                 src_o,
   output logic [15:0]                                vector_o
);
   typedef struct packed {
      logic                        valid;
      logic [mmev_pkg::SRC_W-1:0]  src;
      logic [15:0]                 vector;
   } mmev_sel_type;
   mmev_sel_type s_q, s_d;
   logic [mmev_pkg::LVL_W:0] best_lvl;
   logic [mmev_pkg::LVL_W:0] lvl_n;

   // ------------------------------------------------------------
   // Priority search
   // ------------------------------------------------------------
   always_comb begin
      s_d      = '0;
      best_lvl = '0;
      lvl_n    = '0;
      // Scan from lowest rank upward; ties go to the lower index.
      for (int i = mmev_pkg::NUM_SRC - 1; i >= 0; i--) begin
         // Reset outranks every programmed level.
         lvl_n = (i == 0) ? {1'b1, {mmev_pkg::LVL_W{1'b1}}}
                          : {1'b0, level_i[i*mmev_pkg::LVL_W +: mmev_pkg::LVL_W]};
         if (req_i[i] && (!s_d.valid || lvl_n >= best_lvl)) begin
            s_d.valid = 1'b1;
            s_d.src   = mmev_pkg::SRC_W'(i);
            best_lvl  = lvl_n;
            // Two-byte vectors from the bottom; 0024H is never produced.
            s_d.vector = 16'(i * 2);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign valid_o  = s_q.valid;
   assign src_o    = s_q.src;
   assign vector_o = s_q.vector;
endmodule

//--- dv/mmev_cpu_model.sv
// Purpose: Core side: returns the two handler bytes of each vector.
// Assumes: Handler of vector v is A5 in the high byte, v+10 in the low.
// Notes:   Idle byte lines toggle so a stale value is never read as good.
`timescale 1ns/10ps
module mmev_cpu_model (
   input  wire logic        core_clk_i,
   input  wire logic        slow_i,
   input  wire logic        exc_valid_i,
   input  wire logic [15:0] exc_vector_i,
   input  wire logic        reset_fetch_i,
   output logic             byte_valid_o,
   output logic [7:0]       byte_o
);
   logic [1:0] trig_q = 2'h0;
   initial byte_valid_o = 1'b0;
   initial byte_o = 8'h00;
   always @(posedge core_clk_i) begin
      byte_valid_o <= 1'b0;
      byte_o <= ~byte_o;
      trig_q <= {trig_q[0], exc_valid_i | reset_fetch_i};
      if (slow_i ? trig_q[1] : trig_q[0]) begin
         byte_valid_o <= 1'b1;
         byte_o <= 8'hA5;
      end
      // The reset vector always comes from address zero.
      if (exc_valid_i | reset_fetch_i) begin
         byte_valid_o <= 1'b1;
         byte_o <= (reset_fetch_i ? 8'h00 : exc_vector_i[7:0]) + 8'h10;
      end
   end
endmodule

//--- dv/mmev_top_properties.sv
// Purpose: Port-level checks of the decoder and vector selector.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module mmev_checker (
   input wire logic                         core_clk_i,
   input wire logic                         srst_i,
   input wire logic                         large_rom_i,
   input wire logic [15:0]                  cpu_addr_i,
   input wire logic                         cpu_rd_i,
   input wire logic                         cpu_wr_i,
   input wire logic                         rom_sel_o,
   input wire logic                         ram_sel_o,
   input wire logic                         disp_sel_o,
   input wire logic                         io_sel_o,
   input wire logic                         exc_valid_o,
   input wire logic [mmev_pkg::SRC_W-1:0]   exc_src_o,
   input wire logic [15:0]                  exc_vector_o,
   input wire logic                         save_context_o,
   input wire logic                         custom_branch_condition_o,
   input wire logic                         reset_pin_n_i,
   input wire logic                         cpu_reset_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   logic        acc;
   logic [15:0] rom_top;
   assign acc = cpu_rd_i | cpu_wr_i;
   assign rom_top = large_rom_i ? 16'hEFFF : 16'h7FFF;
   rom_sel_a: assert property (acc |=> rom_sel_o == ($past(cpu_addr_i) <= $past(rom_top)))
      else $error("rom select wrong");
   ram_sel_a: assert property (acc && cpu_addr_i inside {[16'hF000:16'hF5FF]} |=> ram_sel_o)
      else $error("ram select missing");
   io_sel_a: assert property (acc && cpu_addr_i >= 16'hFF00 |=> io_sel_o && !disp_sel_o)
      else $error("io select wrong");
   disp_sel_a: assert property (acc && cpu_addr_i inside {[16'hF800:16'hFD42]} |=> disp_sel_o)
      else $error("display select missing");
   gap_quiet_a: assert property (acc && (cpu_addr_i inside {[16'hF600:16'hF7FF], [16'hFD43:16'hFEFF]}
      || (!large_rom_i && cpu_addr_i inside {[16'h8000:16'hEFFF]}))
      |=> !(rom_sel_o || ram_sel_o || disp_sel_o || io_sel_o)) else $error("gap selected");
   vector_map_a: assert property (exc_valid_o |-> exc_vector_o == {10'h000, exc_src_o, 1'b0}
      && exc_vector_o != 16'h0024) else $error("vector wrong");
   save_ctx_a: assert property (save_context_o == (exc_valid_o && exc_src_o != 5'h00))
      else $error("context save wrong");
   no_custom_a: assert property (!custom_branch_condition_o)
      else $error("custom condition driven");
   pin_reset_a: assert property (!reset_pin_n_i |-> ##[1:2] cpu_reset_o)
      else $error("pin reset ignored");
   cover property (exc_valid_o && exc_src_o == 5'h11);
   cover property ($fell(cpu_reset_o));
   cover property (acc ##1 disp_sel_o);
endmodule
bind mmev_top mmev_checker chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
   .large_rom_i(large_rom_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i),
   .rom_sel_o(rom_sel_o), .ram_sel_o(ram_sel_o), .disp_sel_o(disp_sel_o), .io_sel_o(io_sel_o),
   .exc_valid_o(exc_valid_o), .exc_src_o(exc_src_o), .exc_vector_o(exc_vector_o),
   .save_context_o(save_context_o), .custom_branch_condition_o(custom_branch_condition_o),
   .reset_pin_n_i(reset_pin_n_i), .cpu_reset_o(cpu_reset_o));

//--- dv/mmev_top_test.sv
// Purpose: Self-checking bench for decoder, vectors and reset combiner.
// Assumes: Oscillator tick held high but for one gap, so counts are in clock cycles.
// Notes:   Key hold without sleep is not run; it would need 65535 cycles.
`timescale 1ns/10ps
module memory_map_and_exception_vectors_test;
   logic        clk, srst, large_rom, rd, wr, vbv, slow, rom_s, ram_s, disp_s, io_s, vec_a;
   logic        swi_ok, exc_v, save_c, hv, pin_n, drop_en, drop_smp, drop_lo, drop_hi, sleep;
   logic        cpu_rst, fetch, osc;
   logic [15:0] addr, exc_vec, hand;
   logic [17:0] req;
   logic [35:0] lvl;
   logic [7:0]  vb;
   logic [4:0]  src;
   logic [3:0]  keys_n;
   logic [1:0]  key_sel;
   int          err_count = 0;
   int          checked = 0;
   mmev_top uut (.core_clk_i(clk), .srst_i(srst), .large_rom_i(large_rom), .cpu_addr_i(addr),
      .cpu_rd_i(rd), .cpu_wr_i(wr), .rom_sel_o(rom_s), .ram_sel_o(ram_s), .disp_sel_o(disp_s),
      .io_sel_o(io_s), .vec_area_o(vec_a), .swi_vec_ok_o(swi_ok), .exc_req_i(req),
      .exc_level_i(lvl), .vec_byte_valid_i(vbv), .vec_byte_i(vb), .exc_valid_o(exc_v),
      .exc_src_o(src), .exc_vector_o(exc_vec), .save_context_o(save_c), .handler_addr_o(hand),
      .handler_valid_o(hv), .custom_branch_condition_o(), .reset_pin_n_i(pin_n),
      .key_input_group_low_n_i(keys_n), .key_sel_i(key_sel), .supply_drop_detector_en_i(drop_en),
      .supply_drop_detector_sample_i(drop_smp), .supply_below_level0_i(drop_lo),
      .supply_above_level2_i(drop_hi), .sleep_i(sleep), .osc_tick_i(osc), .cpu_reset_o(cpu_rst),
      .reset_vec_fetch_o(fetch));
   mmev_cpu_model cpu (.core_clk_i(clk), .slow_i(slow), .exc_valid_i(exc_v),
      .exc_vector_i(exc_vec), .reset_fetch_i(fetch), .byte_valid_o(vbv), .byte_o(vb));
   task automatic expect_eq(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_handler(input logic [15:0] exp);
      int n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (hv !== 1'b1 && n < 10);
      expect_eq(hand, exp);
   endtask
   task automatic wait_run(input int ticks);
      int n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (fetch !== 1'b1 && n < 9000);
      expect_eq(n >= ticks && n <= ticks + 4, 1'b1);
      @(posedge clk);
      #1;
      expect_eq(cpu_rst, 1'b0);
      wait_handler(16'hA510);
   endtask
   task automatic t_decode;
      logic [15:0] tab [16] = '{16'h0000, 16'h0023, 16'h0024, 16'h0026, 16'h0027, 16'h00FF,
         16'h7FFF, 16'h8000, 16'hEFFF, 16'hF000, 16'hF5FF, 16'hF600, 16'hF800, 16'hFD42,
         16'hFD43, 16'hFF00};
      logic [5:0]  e;
      for (int l = 0; l < 2; l++) begin
         for (int i = 0; i < 16; i++) begin
            e = {tab[i] <= (l ? 16'hEFFF : 16'h7FFF), tab[i] inside {[16'hF000:16'hF5FF]},
               tab[i] inside {[16'hF800:16'hFD42]}, tab[i] >= 16'hFF00, tab[i] <= 16'h0023,
               tab[i] >= 16'h0026 && tab[i] <= 16'h00FF && !tab[i][0]};
            @(posedge clk);
            large_rom <= l[0];
            addr <= tab[i];
            rd <= i[0];
            wr <= !i[0];
            @(posedge clk);
            #1;
            expect_eq({rom_s, ram_s, disp_s, io_s, vec_a, swi_ok}, e);
         end
      end
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic t_exc(input logic [17:0] r, input logic [35:0] l, input logic [4:0] s);
      @(posedge clk);
      req <= r;
      lvl <= l;
      slow <= s[0];
      @(posedge clk);
      req <= '0;
      #1;
      expect_eq(exc_v, 1'b1);
      expect_eq(src, s);
      expect_eq(exc_vec, {10'h000, s, 1'b0});
      expect_eq(save_c, s != 5'h00);
      wait_handler({8'hA5, 8'h10 + {2'b00, s, 1'b0}});
   endtask
   task automatic drop_pulse(input logic low);
      @(posedge clk);
      drop_smp <= 1'b1;
      drop_lo <= low;
      drop_hi <= !low;
      @(posedge clk);
      drop_smp <= 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #600000;
      err_count++;
      stop_test;
   end
   initial begin
      {srst, pin_n, keys_n} = 6'h2F; // first reset from the pin
      {large_rom, addr, rd, wr, req, lvl, key_sel, drop_en, drop_smp, drop_lo, sleep, slow} = '0;
      {drop_hi, osc} = 2'h3;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (20) @(posedge clk);
      pin_n <= 1'b1;
      wait_run(8192);
      t_decode;
      for (int i = 0; i < 18; i++) t_exc(18'h1 << i, 36'h0, i[4:0]);
      t_exc(18'h20022, 36'hC00000000, 5'h11);
      t_exc(18'h00220, 36'h0, 5'h05);
      t_exc(18'h3FFFF, 36'h0, 5'h00);
      @(posedge clk);
      keys_n <= 4'h0;
      repeat (30) @(posedge clk);
      #1;
      expect_eq(cpu_rst, 1'b0);
      for (int s = 1; s < 4; s++) begin
         @(posedge clk);
         key_sel <= s[1:0];
         sleep <= 1'b1;
         keys_n <= 4'hF << (s + 1);
         repeat (4) @(posedge clk);
         #1;
         expect_eq(cpu_rst, 1'b1);
         @(posedge clk);
         {keys_n, sleep} <= 5'h1E;
         wait_run(8192);
      end
      @(posedge clk);
      drop_en <= 1'b1;
      repeat (3) drop_pulse(1'b1);
      drop_pulse(1'b0);
      repeat (4) @(posedge clk);
      #1;
      expect_eq(cpu_rst, 1'b0);
      repeat (4) drop_pulse(1'b1);
      repeat (2) @(posedge clk);
      #1;
      expect_eq(cpu_rst, 1'b1);
      // Without oscillator ticks the stabilisation count must stand still.
      @(posedge clk);
      osc <= 1'b0;
      drop_pulse(1'b0);
      repeat (100) @(posedge clk);
      osc <= 1'b1;
      wait_run(8440);
      stop_test;
   end
endmodule
